// [hw/tegc_pkg.sv]
// Shared constants and types for the test execution group control block.
// Assumes one module clock and a command decoder that delivers one-cycle commands.
package tegc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int STEP_W = 14;
   localparam int PIN_W  = 64;
   localparam int EV_W   = 8;
   localparam int EVQ_D  = 8;

   ////////////////////////////////////////////////////////////////////////
   // Configuration report values
   localparam logic [13:0] CFG_STEPS   = 14'h3fdf;
   localparam logic [6:0]  CFG_PINS    = 7'h40;
   localparam logic [21:0] CFG_PER_MIN = 22'h000032;
   localparam logic [21:0] CFG_PER_MAX = 22'h31ff9c;
   localparam logic [21:0] CFG_PER_RES = 22'h000032;
   localparam logic [1:0]  CFG_PODS    = 2'h2;

   ////////////////////////////////////////////////////////////////////////
   // Reset values; all encodings below are chosen so reset is all zero
   localparam logic [7:0]  MASK_RST    = 8'h00;
   localparam logic        TRIG_ON_RST = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Argument fields
   localparam int ARG_TRIG_NONE = 3;
   localparam int ARG_CLK_INT   = 0;

   typedef enum logic [1:0] {
      ROLE_SINGLE = 2'b00,
      ROLE_LEADER = 2'b01,
      ROLE_MEMBER = 2'b10,
      ROLE_SLAVE  = 2'b11
   } tegc_role_type;

   typedef enum logic [1:0] {
      EX_STOP  = 2'b00,
      EX_RUN   = 2'b01,
      EX_PAUSE = 2'b10
   } tegc_exec_type;

   typedef enum logic [3:0] {
      OP_NOP    = 4'h0,
      OP_ROLE   = 4'h1,
      OP_TRIG   = 4'h2,
      OP_CLKSRC = 4'h3,
      OP_ARM    = 4'h4,
      OP_START  = 4'h5,
      OP_STOP   = 4'h6,
      OP_PAUSE  = 4'h7,
      OP_RESUME = 4'h8,
      OP_MASK   = 4'h9,
      OP_EVREAD = 4'ha
   } tegc_op_type;

endpackage

// [hw/tegc_ctrl.sv]
// Test execution control: roles, start/stop line, first-failure capture,
// event queue and event enable mask.
// Assumes the sequencer and command decoder share clk; trigger pins are async.
`timescale 1ns/10ps

// Contract
// - In slave role the resume command never restarts a paused test.
// - Eight-bit event enable mask, read and write, gates standard events.
// - Report 16351 steps, 64 pins, period 50..3276700 ns by 50, 2 pods.
// - Usable step range is the smallest of module and attached pods.
// - Event read returns newest queued event and removes it.
// - First failure latches sequence and pin state; later failures ignored.
// - Failure sequence reads -1 after a pass; pin state then invalid.
// - First failure also latches a per-pin failure mask.
// - Failure mask bit per pin, pin 0 in the lowest bit.
// - Roles single, leader, member, slave; leader drives line, member follows.
// - Slave role starts and pauses with the selected trigger line level.
// - Slave role ignores the trigger line until armed.
// - Slave runs while line asserted, pauses while deasserted, until end; after a seq_pause_flag pause the code stays paused until the line drops and rises again.
// - Early end: manager drops line, host stops each module.
// - Slave role allowed only with the internal clock selected.
module tegc_ctrl #(
   parameter int STEP_W = tegc_pkg::STEP_W,
   parameter int PIN_W  = tegc_pkg::PIN_W,
   parameter int EV_W   = tegc_pkg::EV_W,
   parameter int EVQ_D  = tegc_pkg::EVQ_D
) (
   input  logic                    clk,
   input  logic                    rst,
   input  logic                    cmd_valid,
   input  tegc_pkg::tegc_op_type   cmd_op,
   input  logic [7:0]              cmd_arg,
   input  logic [7:0]              ttl_trig_in,
   output logic [7:0]              ttl_trig_out,
   output logic [7:0]              ttl_trig_oe,
   input  logic                    seq_end,
   input  logic                    seq_pause_flag,
   input  logic                    cmp_fail,
   input  logic [STEP_W-1:0]       seq_num,
   input  logic [PIN_W-1:0]        pin_state,
   input  logic [PIN_W-1:0]        pin_fail,
   input  logic [1:0]              pod_present,
   input  logic [STEP_W-1:0]       pod0_steps,
   input  logic [STEP_W-1:0]       pod1_steps,
   input  logic [7:0]              std_event,
   input  logic                    ev_push,
   input  logic [EV_W-1:0]         ev_push_code,
   output tegc_pkg::tegc_exec_type exec_state,
   output tegc_pkg::tegc_role_type execution_role,
   output logic                    trig_assigned,
   output logic [2:0]              trig_line,
   output logic                    clk_internal,
   output logic                    armed,
   output logic                    role_refused,
   output logic [7:0]              event_enable_mask,
   output logic [7:0]              std_event_enabled,
   output logic                    std_event_summary,
   output logic [EV_W-1:0]         event_code,
   output logic                    event_valid,
   output logic                    event_empty,
   output logic signed [STEP_W:0]  fail_seq,
   output logic                    fail_valid,
   output logic                    test_passed,
   output logic [PIN_W-1:0]        fail_state,
   output logic [PIN_W-1:0]        fail_mask,
   output logic [STEP_W-1:0]       step_limit,
   output logic [13:0]             cfg_steps,
   output logic [6:0]              cfg_pins,
   output logic [21:0]             cfg_period_min,
   output logic [21:0]             cfg_period_max,
   output logic [21:0]             cfg_period_res,
   output logic [1:0]              cfg_pods
);

   localparam int CW = $clog2(EVQ_D + 1);
   localparam logic [STEP_W-1:0] CFG_LIMIT_INIT = STEP_W'(tegc_pkg::CFG_STEPS);

   typedef struct packed {
      logic [7:0]                   sync1;
      logic [7:0]                   sync2;
      logic                         line_d;
      tegc_pkg::tegc_role_type      role;
      logic                         trig_on;
      logic [2:0]                   trig_idx;
      logic                         clk_int;
      logic                         role_err;
      logic [7:0]                   mask;
      logic                         armed;
      tegc_pkg::tegc_exec_type      ex;
      logic                         need_low;
      logic                         fail_hit;
      logic                         passed;
      logic [STEP_W-1:0]            fseq;
      logic [PIN_W-1:0]             fstate;
      logic [PIN_W-1:0]             fmask;
      logic [EVQ_D-1:0][EV_W-1:0]   evq;
      logic [CW-1:0]                evn;
      logic [EV_W-1:0]              ev_out;
      logic                         ev_valid;
      logic [STEP_W-1:0]            limit;
   } tegc_state_type;

   tegc_state_type s;
   tegc_state_type next_s;
   logic           line;
   logic           rise;
   logic           leads;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Starting a run clears the failure flag and pass result; fseq, fstate and fmask keep their values
   function automatic tegc_state_type f_start(input tegc_state_type x);
      tegc_state_type y;
      y          = x;
      y.ex       = tegc_pkg::EX_RUN;
      y.fail_hit = 1'b0;
      y.passed   = 1'b0;
      y.need_low = 1'b0;
      return y;
   endfunction

   function automatic logic [STEP_W-1:0] f_min(input logic [STEP_W-1:0] a,
                                               input logic [STEP_W-1:0] b);
      return (a < b) ? a : b;
   endfunction

   // Only the second sync stage is read
   assign line  = s.trig_on & s.sync2[s.trig_idx];
   assign rise  = line & ~s.line_d;
   assign leads = (s.role == tegc_pkg::ROLE_SINGLE) | (s.role == tegc_pkg::ROLE_LEADER);

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_s          = s;
      next_s.sync1    = ttl_trig_in;
      next_s.sync2    = s.sync1;
      next_s.line_d   = line;
      next_s.ev_valid = 1'b0;

      next_s.limit = CFG_LIMIT_INIT;
      if (pod_present[0]) begin
         next_s.limit = f_min(next_s.limit, pod0_steps);
      end
      if (pod_present[1]) begin
         next_s.limit = f_min(next_s.limit, pod1_steps);
      end

      // Sequencer events
      if (s.ex == tegc_pkg::EX_RUN) begin
         if (cmp_fail && !s.fail_hit) begin
            next_s.fail_hit = 1'b1;
            next_s.fseq     = seq_num;
            next_s.fstate   = pin_state;
            next_s.fmask    = pin_fail;
         end
         if (seq_end) begin
            next_s.ex     = tegc_pkg::EX_STOP;
            next_s.passed = !(s.fail_hit | cmp_fail);
         end else if (seq_pause_flag) begin
            next_s.ex       = tegc_pkg::EX_PAUSE;
            next_s.need_low = 1'b1;
         end
      end

      // Line-governed roles
      if (s.role == tegc_pkg::ROLE_MEMBER) begin
         if (rise && s.ex == tegc_pkg::EX_STOP) begin
            next_s = f_start(next_s);
         end else if (line && s.ex == tegc_pkg::EX_PAUSE) begin
            next_s.ex = tegc_pkg::EX_RUN;
         end else if (!line && next_s.ex == tegc_pkg::EX_RUN) begin
            next_s.ex = tegc_pkg::EX_PAUSE;
         end
      end else if (s.role == tegc_pkg::ROLE_SLAVE) begin
         if (s.ex == tegc_pkg::EX_STOP) begin
            // Unarmed slaves see no line activity at all
            if (s.armed && rise) begin
               next_s       = f_start(next_s);
               next_s.armed = 1'b0;
            end
         end else if (s.ex == tegc_pkg::EX_PAUSE) begin
            if (!line) begin
               next_s.need_low = 1'b0;
            end else if (!s.need_low) begin
               next_s.ex = tegc_pkg::EX_RUN;
            end
         end else if (!line && next_s.ex == tegc_pkg::EX_RUN) begin
            next_s.ex = tegc_pkg::EX_PAUSE;
         end
      end

      // Event queue push, newest at index 0; a full queue drops the oldest
      if (ev_push) begin
         for (int i = EVQ_D - 1; i > 0; i--) begin
            next_s.evq[i] = s.evq[i-1];
         end
         next_s.evq[0] = ev_push_code;
         if (s.evn != CW'(EVQ_D)) begin
            next_s.evn = s.evn + 1'b1;
         end
      end

      if (cmd_valid) begin
         unique case (cmd_op)
            tegc_pkg::OP_ROLE: begin
               if (tegc_pkg::tegc_role_type'(cmd_arg[1:0]) == tegc_pkg::ROLE_SLAVE && !s.clk_int) begin
                  next_s.role_err = 1'b1;
               end else begin
                  next_s.role     = tegc_pkg::tegc_role_type'(cmd_arg[1:0]);
                  next_s.role_err = 1'b0;
               end
            end
            tegc_pkg::OP_CLKSRC: begin
               next_s.clk_int = cmd_arg[tegc_pkg::ARG_CLK_INT];
               // Leaving the internal clock drops the slave role
               if (!cmd_arg[tegc_pkg::ARG_CLK_INT] && s.role == tegc_pkg::ROLE_SLAVE) begin
                  next_s.role = tegc_pkg::ROLE_SINGLE;
               end
            end
            tegc_pkg::OP_TRIG: begin
               next_s.trig_on  = !cmd_arg[tegc_pkg::ARG_TRIG_NONE];
               next_s.trig_idx = cmd_arg[2:0];
            end
            tegc_pkg::OP_ARM: begin
               next_s.armed = 1'b1;
            end
            tegc_pkg::OP_START: begin
               if (leads && s.ex == tegc_pkg::EX_STOP) begin
                  next_s = f_start(next_s);
               end
            end
            tegc_pkg::OP_STOP: begin
               next_s.ex       = tegc_pkg::EX_STOP;
               next_s.armed    = 1'b0;
               next_s.need_low = 1'b0;
            end
            tegc_pkg::OP_PAUSE: begin
               if (leads && s.ex == tegc_pkg::EX_RUN) begin
                  next_s.ex = tegc_pkg::EX_PAUSE;
               end
            end
            tegc_pkg::OP_RESUME: begin
               // Slave and member roles ignore resume
               if (leads && s.ex == tegc_pkg::EX_PAUSE) begin
                  next_s.ex = tegc_pkg::EX_RUN;
               end
            end
            tegc_pkg::OP_MASK: begin
               next_s.mask = cmd_arg;
            end
            tegc_pkg::OP_EVREAD: begin
               // Pop reads the queue as it was before this cycle's push
               if (s.evn != '0) begin
                  next_s.ev_out   = s.evq[0];
                  next_s.ev_valid = 1'b1;
                  if (!ev_push) begin
                     for (int i = 0; i < EVQ_D - 1; i++) begin
                        next_s.evq[i] = s.evq[i+1];
                     end
                     next_s.evn = s.evn - 1'b1;
                  end else begin
                     // Only the newest slot is replaced; older entries keep their places
                     for (int i = 1; i < EVQ_D; i++) begin
                        next_s.evq[i] = s.evq[i];
                     end
                     next_s.evn = s.evn;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign ttl_trig_out      = {8{s.ex == tegc_pkg::EX_RUN}};
   assign ttl_trig_oe       = (s.role == tegc_pkg::ROLE_LEADER && s.trig_on) ? (8'h01 << s.trig_idx) : 8'h00;
   assign exec_state        = s.ex;
   assign execution_role    = s.role;
   assign trig_assigned     = s.trig_on;
   assign trig_line         = s.trig_idx;
   assign clk_internal      = s.clk_int;
   assign armed             = s.armed;
   assign role_refused      = s.role_err;
   assign event_enable_mask = s.mask;
   assign std_event_enabled = std_event & s.mask;
   assign std_event_summary = |std_event_enabled;
   assign event_code        = s.ev_out;
   assign event_valid       = s.ev_valid;
   assign event_empty       = (s.evn == '0);
   assign fail_seq          = s.fail_hit ? {1'b0, s.fseq} : '1;
   assign fail_valid        = s.fail_hit;
   assign test_passed       = s.passed;
   assign fail_state        = s.fstate;
   assign fail_mask         = s.fmask;
   assign step_limit        = s.limit;
   assign cfg_steps         = tegc_pkg::CFG_STEPS;
   assign cfg_pins          = tegc_pkg::CFG_PINS;
   assign cfg_period_min    = tegc_pkg::CFG_PER_MIN;
   assign cfg_period_max    = tegc_pkg::CFG_PER_MAX;
   assign cfg_period_res    = tegc_pkg::CFG_PER_RES;
   assign cfg_pods          = tegc_pkg::CFG_PODS;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   AST_SLAVE_NO_RESUME: assert property (@(posedge clk) disable iff (rst)
      s.role == tegc_pkg::ROLE_SLAVE && s.ex == tegc_pkg::EX_PAUSE && s.need_low
      |=> s.ex != tegc_pkg::EX_RUN)
      else $error("slave resumed without line drop");

   AST_MASK_WRITE: assert property (@(posedge clk) disable iff (rst)
      cmd_valid && cmd_op == tegc_pkg::OP_MASK
      |=> event_enable_mask == $past(cmd_arg) && std_event_enabled == (std_event & $past(cmd_arg)))
      else $error("mask write not applied");

   AST_STEP_LIMIT: assert property (@(posedge clk) disable iff (rst)
      pod_present[0] |=> step_limit <= $past(pod0_steps) && step_limit <= tegc_pkg::CFG_STEPS)
      else $error("step limit above pod range");

   AST_EVENT_POP: assert property (@(posedge clk) disable iff (rst)
      cmd_valid && cmd_op == tegc_pkg::OP_EVREAD && !event_empty && !ev_push
      |=> event_valid && event_code == $past(s.evq[0]) && s.evn == $past(s.evn) - 1'b1)
      else $error("event read wrong");

   AST_FIRST_FAIL_HOLD: assert property (@(posedge clk) disable iff (rst)
      s.fail_hit && s.ex != tegc_pkg::EX_STOP
      |=> $stable(fail_seq) && $stable(fail_mask) && $stable(fail_state))
      else $error("failure record overwritten");

   AST_FIRST_FAIL_TAKE: assert property (@(posedge clk) disable iff (rst)
      s.ex == tegc_pkg::EX_RUN && !s.fail_hit && cmp_fail
      |=> fail_valid && fail_mask == $past(pin_fail) && fail_seq[STEP_W-1:0] == $past(seq_num))
      else $error("first failure not latched");

   AST_PASS_MINUS_ONE: assert property (@(posedge clk) disable iff (rst)
      !fail_valid |-> fail_seq == -1)
      else $error("fail sequence not -1");

   AST_LEADER_DRIVES: assert property (@(posedge clk) disable iff (rst)
      s.role == tegc_pkg::ROLE_LEADER && s.trig_on
      |-> ttl_trig_oe[s.trig_idx] && ttl_trig_out[s.trig_idx] == (exec_state == tegc_pkg::EX_RUN))
      else $error("leader not driving line");

   AST_SLAVE_LINE_LOW: assert property (@(posedge clk) disable iff (rst)
      s.role == tegc_pkg::ROLE_SLAVE && s.ex == tegc_pkg::EX_RUN && !line
      |=> s.ex != tegc_pkg::EX_RUN)
      else $error("slave kept running on low line");

   AST_UNARMED_IDLE: assert property (@(posedge clk) disable iff (rst)
      s.role == tegc_pkg::ROLE_SLAVE && s.ex == tegc_pkg::EX_STOP && !s.armed
      |=> s.ex == tegc_pkg::EX_STOP)
      else $error("unarmed slave started");

   AST_SLAVE_CLOCK: assert property (@(posedge clk) disable iff (rst)
      s.role == tegc_pkg::ROLE_SLAVE |-> s.clk_int)
      else $error("slave role without internal clock");

   AST_RESET_DEFAULT: assert property (@(posedge clk) disable iff (rst)
      $fell(rst) |-> execution_role == tegc_pkg::ROLE_SINGLE && !trig_assigned && event_enable_mask == 8'h00)
      else $error("reset defaults wrong");

endmodule // tegc_ctrl

// [test/tegc_stst_mgr.sv]
// Far-side model: start/stop source on the shared trigger lines.
// Assumes the bench picks the line, the wanted level and the response lag.
`timescale 1ns/10ps
module tegc_stst_mgr (
   input  logic       clk,
   input  logic [2:0] line,
   input  logic       level,
   input  logic [3:0] lag,
   output logic [7:0] trig
);
   ////////////////////////////////////////////////////////////////////////
   logic [15:0] hist = 16'h0000;
   logic        noise = 1'b0;

   // Level history lets the source answer promptly or slowly
   always @(posedge clk) begin
      hist  <= {hist[14:0], level};
      noise <= ~noise;
   end

   // Unowned lines toggle so a wrong line selection cannot pass by luck
   always_comb begin
      trig       = {8{noise}};
      trig[line] = hist[lag];
   end
endmodule // tegc_stst_mgr

// [test/tegc_ctrl_tb.sv]
// Self-checking bench for the execution control block.
// Assumes the stst model on the trigger lines; all else driven here.
`timescale 1ns/10ps
module tegc_ctrl_tb;
   logic clk, rst, cmd_valid, seq_end, seq_pause_flag, cmp_fail, ev_push, mgr_level;
   tegc_pkg::tegc_op_type   cmd_op;
   tegc_pkg::tegc_exec_type exec_state;
   tegc_pkg::tegc_role_type execution_role;
   logic [7:0]  cmd_arg, std_event, ev_push_code, ttl_trig_in, ttl_trig_out, ttl_trig_oe, mgr_trig;
   logic [7:0]  event_enable_mask, std_event_enabled, event_code;
   logic [13:0] seq_num, pod0_steps, pod1_steps, step_limit, cfg_steps;
   logic [63:0] pin_state, pin_fail, fail_state, fail_mask;
   logic [21:0] cfg_period_min, cfg_period_max, cfg_period_res;
   logic [1:0]  pod_present, cfg_pods;
   logic [2:0]  mgr_line, trig_line;
   logic [3:0]  mgr_lag;
   logic [6:0]  cfg_pins;
   logic        trig_assigned, clk_internal, armed, role_refused, std_event_summary;
   logic        event_valid, event_empty, fail_valid, test_passed;
   logic signed [14:0] fail_seq;
   int          n_fail, checks_done;

   ////////////////////////////////////////////////////////////////////////
   // Wired level: the leader's enable wins over the far-side source
   assign ttl_trig_in = (ttl_trig_oe & ttl_trig_out) | (~ttl_trig_oe & mgr_trig);

   tegc_stst_mgr u_mgr (.clk(clk), .line(mgr_line), .level(mgr_level), .lag(mgr_lag), .trig(mgr_trig));

   tegc_ctrl u_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg),
      .ttl_trig_in(ttl_trig_in), .ttl_trig_out(ttl_trig_out), .ttl_trig_oe(ttl_trig_oe),
      .seq_end(seq_end), .seq_pause_flag(seq_pause_flag), .cmp_fail(cmp_fail), .seq_num(seq_num),
      .pin_state(pin_state), .pin_fail(pin_fail), .pod_present(pod_present), .pod0_steps(pod0_steps),
      .pod1_steps(pod1_steps), .std_event(std_event), .ev_push(ev_push), .ev_push_code(ev_push_code),
      .exec_state(exec_state), .execution_role(execution_role), .trig_assigned(trig_assigned),
      .trig_line(trig_line), .clk_internal(clk_internal), .armed(armed), .role_refused(role_refused),
      .event_enable_mask(event_enable_mask), .std_event_enabled(std_event_enabled),
      .std_event_summary(std_event_summary), .event_code(event_code), .event_valid(event_valid),
      .event_empty(event_empty), .fail_seq(fail_seq), .fail_valid(fail_valid), .test_passed(test_passed),
      .fail_state(fail_state), .fail_mask(fail_mask), .step_limit(step_limit), .cfg_steps(cfg_steps),
      .cfg_pins(cfg_pins), .cfg_period_min(cfg_period_min), .cfg_period_max(cfg_period_max),
      .cfg_period_res(cfg_period_res), .cfg_pods(cfg_pods));

   always #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic ck(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic cmd(input tegc_pkg::tegc_op_type op, input logic [7:0] a);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_op    <= op;
      cmd_arg   <= a;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_op    <= tegc_pkg::OP_NOP;
      #1;
   endtask

   task automatic drive_line(input logic l);
      @(posedge clk);
      mgr_level <= l;
      #1;
   endtask

   // Bounded wait; running out counts a mismatch and closes the run
   task automatic wait_st(input tegc_pkg::tegc_exec_type e);
      for (int i = 0; i < 20; i++) begin
         if (exec_state === e) break;
         cyc(1);
      end
      ck(exec_state === e, "execution state not reached");
      if (exec_state !== e) end_of_test();
   endtask

   task automatic sq(input logic f, input logic e, input logic p, input logic [13:0] n, input logic [63:0] pf);
      @(posedge clk);
      cmp_fail       <= f;
      seq_end        <= e;
      seq_pause_flag <= p;
      seq_num        <= n;
      pin_state      <= ~pf ^ {n, n, n, n, 8'h5a};
      pin_fail       <= pf;
      @(posedge clk);
      cmp_fail       <= 1'b0;
      seq_end        <= 1'b0;
      seq_pause_flag <= 1'b0;
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      ck(execution_role === tegc_pkg::ROLE_SINGLE && trig_assigned === 1'b0, "reset role");
      ck(event_enable_mask === 8'h00 && exec_state === tegc_pkg::EX_STOP, "reset mask");
      ck(cfg_steps === 14'h3fdf && cfg_pins === 7'h40 && cfg_pods === 2'h2, "config counts");
      ck(cfg_period_min === 22'h000032 && cfg_period_max === 22'h31ff9c && cfg_period_res === 22'h000032,
         "config period");
      ck(fail_seq === 15'h7fff, "reset failure sequence");
   endtask

   task automatic t_mask;
      logic [7:0] v [3] = '{8'h00, 8'ha5, 8'hff};
      std_event <= 8'h3c;
      for (int i = 0; i < 3; i++) begin
         cmd(tegc_pkg::OP_MASK, v[i]);
         ck(event_enable_mask === v[i], "mask readback");
         ck(std_event_enabled === (v[i] & 8'h3c) && std_event_summary === |(v[i] & 8'h3c), "gating");
      end
   endtask

   task automatic t_limit;
      logic [13:0] ex [4] = '{14'h3fdf, 14'h0064, 14'h0032, 14'h0032};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         pod_present <= i[1:0];
         pod0_steps  <= 14'h0064;
         pod1_steps  <= 14'h0032;
         cyc(3);
         ck(step_limit === ex[i], "step limit");
      end
   endtask

   task automatic t_queue;
      for (int i = 1; i < 4; i++) begin
         @(posedge clk);
         ev_push      <= 1'b1;
         ev_push_code <= 8'h11 * i[7:0];
         @(posedge clk);
         ev_push <= 1'b0;
      end
      for (int i = 3; i > 0; i--) begin
         cmd(tegc_pkg::OP_EVREAD, 8'h00);
         ck(event_valid === 1'b1 && event_code === 8'h11 * i[7:0], "newest event first");
      end
      cyc(1);
      ck(event_empty === 1'b1, "queue drained");
      cmd(tegc_pkg::OP_EVREAD, 8'h00);
      ck(event_valid === 1'b0, "read of empty queue");
   endtask

   task automatic t_fail;
      cmd(tegc_pkg::OP_START, 8'h00);
      wait_st(tegc_pkg::EX_RUN);
      sq(1'b1, 1'b0, 1'b0, 14'h000a, 64'h8000000000000001);
      sq(1'b1, 1'b0, 1'b0, 14'h0014, 64'hffffffffffffffff);
      ck(fail_valid === 1'b1 && fail_seq === 15'h000a, "first failure step");
      ck(fail_state === (64'h7ffffffffffffffe ^ {14'h000a, 14'h000a, 14'h000a, 14'h000a, 8'h5a}),
         "first failure pins");
      ck(fail_mask === 64'h8000000000000001, "first failure mask");
      sq(1'b0, 1'b1, 1'b0, 14'h0015, 64'h0);
      wait_st(tegc_pkg::EX_STOP);
      ck(test_passed === 1'b0, "failed run");
      cmd(tegc_pkg::OP_START, 8'h00);
      ck(fail_valid === 1'b0, "capture rearmed");
      sq(1'b0, 1'b1, 1'b0, 14'h0003, 64'h0);
      ck(fail_seq === 15'h7fff && test_passed === 1'b1, "passed run");
   endtask

   task automatic t_leader;
      cmd(tegc_pkg::OP_ROLE, 8'h01);
      cmd(tegc_pkg::OP_TRIG, 8'h05);
      cmd(tegc_pkg::OP_START, 8'h00);
      cyc(1);
      ck(ttl_trig_oe === 8'h20 && ttl_trig_out === 8'hff && exec_state === tegc_pkg::EX_RUN, "leader");
      cmd(tegc_pkg::OP_PAUSE, 8'h00);
      cyc(1);
      ck(exec_state === tegc_pkg::EX_PAUSE && ttl_trig_out === 8'h00, "leader pause");
      cmd(tegc_pkg::OP_RESUME, 8'h00);
      wait_st(tegc_pkg::EX_RUN);
      cmd(tegc_pkg::OP_STOP, 8'h00);
      wait_st(tegc_pkg::EX_STOP);
   endtask

   task automatic t_member;
      mgr_line <= 3'h1;
      mgr_lag  <= 4'h6;
      cmd(tegc_pkg::OP_TRIG, 8'h01);
      cmd(tegc_pkg::OP_ROLE, 8'h02);
      drive_line(1'b1);
      wait_st(tegc_pkg::EX_RUN);
      ck(ttl_trig_oe === 8'h00, "member does not drive");
      drive_line(1'b0);
      wait_st(tegc_pkg::EX_PAUSE);
      drive_line(1'b1);
      wait_st(tegc_pkg::EX_RUN);
      cmd(tegc_pkg::OP_STOP, 8'h00);
      wait_st(tegc_pkg::EX_STOP);
      drive_line(1'b0);
   endtask

   task automatic t_slave;
      mgr_lag <= 4'h0;
      cyc(10);
      cmd(tegc_pkg::OP_ROLE, 8'h03);
      ck(role_refused === 1'b1 && execution_role === tegc_pkg::ROLE_MEMBER, "slave without clock");
      cmd(tegc_pkg::OP_CLKSRC, 8'h01);
      cmd(tegc_pkg::OP_ROLE, 8'h03);
      cmd(tegc_pkg::OP_TRIG, 8'h03);
      mgr_line <= 3'h3;
      ck(execution_role === tegc_pkg::ROLE_SLAVE && trig_line === 3'h3 && clk_internal === 1'b1,
         "slave role");
      drive_line(1'b1);
      cyc(8);
      ck(exec_state === tegc_pkg::EX_STOP, "line ignored before arm");
      drive_line(1'b0);
      cyc(6);
      cmd(tegc_pkg::OP_ARM, 8'h00);
      ck(armed === 1'b1, "arm");
      drive_line(1'b1);
      wait_st(tegc_pkg::EX_RUN);
      drive_line(1'b0);
      wait_st(tegc_pkg::EX_PAUSE);
      drive_line(1'b1);
      wait_st(tegc_pkg::EX_RUN);
      sq(1'b0, 1'b0, 1'b1, 14'h0020, 64'h0);
      ck(exec_state === tegc_pkg::EX_PAUSE, "step flag pause");
      cmd(tegc_pkg::OP_RESUME, 8'h00);
      cyc(6);
      ck(exec_state === tegc_pkg::EX_PAUSE, "resume ignored");
      drive_line(1'b0);
      cyc(6);
      ck(exec_state === tegc_pkg::EX_PAUSE, "still paused");
      drive_line(1'b1);
      wait_st(tegc_pkg::EX_RUN);
      drive_line(1'b0);
      wait_st(tegc_pkg::EX_PAUSE);
      cmd(tegc_pkg::OP_STOP, 8'h00);
      ck(exec_state === tegc_pkg::EX_STOP, "early end");
      cmd(tegc_pkg::OP_TRIG, 8'h08);
      cmd(tegc_pkg::OP_CLKSRC, 8'h00);
      ck(trig_assigned === 1'b0 && execution_role === tegc_pkg::ROLE_SINGLE, "no line, role dropped");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0; rst = 1'b1; cmd_valid = 1'b0; cmd_op = tegc_pkg::OP_NOP; cmd_arg = 8'h00;
      seq_end = 1'b0; seq_pause_flag = 1'b0; cmp_fail = 1'b0; seq_num = 14'h0000;
      pin_state = 64'h0; pin_fail = 64'h0; pod_present = 2'h0; pod0_steps = 14'h0000;
      pod1_steps = 14'h0000; std_event = 8'h00; ev_push = 1'b0; ev_push_code = 8'h00;
      mgr_level = 1'b0; mgr_line = 3'h0; mgr_lag = 4'h0; n_fail = 0; checks_done = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      t_reset();
      t_mask();
      t_limit();
      t_queue();
      t_fail();
      t_leader();
      t_member();
      t_slave();
      end_of_test();
   end
endmodule // tegc_ctrl_tb
